/* File: logic/frm_defines.svh */
// constants and rule summary for the replay and mail block
//
// Contract
// [R1] Mark word and enter replay when valid
// [R2] Replay ends on edge with hold low
// [R3] Replay needs two reads past mark
// [R4] Replay edge reloads first marked word
// [R5] Replay loops repeat while mode active
// [R6] Controller holds replay low at exit
// [R7] Current pointer drives valid and near-empty
// [R8] Shadow pointer frozen, drives write flags
// [R9] Near-full falls at limit from mark
// [R10] Space flag falls on full write
// [R11] Replay loads pointer, valid updates immediately
// [R12] Near-empty rises within two edges after
// [R13] Exit moves write flags to current pointer
// [R14] Write-flag rise takes two port-A edges
// [R15] Two mail registers, select picks path
// [R16] Port A write loads mail one
// [R17] Port B write loads mail two
// [R18] Write drops full flag, blocks rewrite
// [R19] Port B mux, port A mail two
// [R20] Port B mail read frees mail one
// [R21] Port A mail read frees mail two
// [R22] Mail contents kept until rewritten
// [R23] Invalid output ignores reads, keeps word
// [R24] Near-full low at count limit
// [R25] Replay request ignored outside replay
`ifndef FRM_DEFINES_SVH
`define FRM_DEFINES_SVH
// flag values after reset
`define FRM_RST_MAIL_FULL_N  1'b1
`define FRM_RST_SPACE_AVAIL  1'b1
`define FRM_RST_NEAR_FULL_N  1'b1
`define FRM_RST_NEAR_EMPTY_N 1'b0
`define FRM_RST_OUT_VALID    1'b0
// reads needed past the marked word before a replay
`define FRM_MIN_READS_PAST   2'h2
`endif

/* File: logic/frm_pkg.sv */
// shared types for the replay and mail block
package frm_pkg;
  // control pins of one port, sampled together
  typedef struct packed {
    logic clk;
    logic chip_sel_n;
    logic write_not_read;
    logic enable;
    logic mail_sel;
  } frm_port_ctl_t;
  // replay pins of port b
  typedef struct packed {
    logic hold;
    logic from_mark;
  } frm_replay_ctl_t;
endpackage

/* File: logic/frm_top.sv */
// replay control, flags and mail registers of a 1024x36 port fifo
`timescale 1ns/100ps
`default_nettype none
`include "frm_defines.svh"
module frm_top #(
  parameter int AW = 10,  // fifo address width, 1024 words
  parameter int DW = 36   // word width
) (
  // system clock and reset
  input  wire  logic          CLK_I,
  input  wire  logic          RST_B_I,
  // port a pins
  input  wire  frm_pkg::frm_port_ctl_t PORT_A_CTL_I,
  input  wire  logic [DW-1:0] PORT_A_DATA_BUS_I,
  output logic [DW-1:0]       PORT_A_DATA_BUS_O,
  output logic                PORT_A_DATA_BUS_OE_O,
  output logic                IN_SPACE_AVAIL_O,
  output logic                NEAR_FULL_N_O,
  output logic                MAIL_TWO_FULL_N_O,
  // port b pins
  input  wire  frm_pkg::frm_port_ctl_t PORT_B_CTL_I,
  input  wire  frm_pkg::frm_replay_ctl_t PORT_B_REPLAY_I,
  input  wire  logic [DW-1:0] PORT_B_DATA_BUS_I,
  output logic [DW-1:0]       PORT_B_DATA_BUS_O,
  output logic                PORT_B_DATA_BUS_OE_O,
  output logic                OUT_WORD_VALID_O,
  output logic                NEAR_EMPTY_N_O,
  output logic                MAIL_ONE_FULL_N_O,
  // flag offsets from the offset logic
  input  wire  logic [AW-1:0] NEAR_EMPTY_OFS_I,
  input  wire  logic [AW-1:0] NEAR_FULL_OFS_I,
  // fifo core array
  output logic                FIFO_WR_O,
  output logic [AW-1:0]       FIFO_WR_ADDR_O,
  output logic [DW-1:0]       FIFO_WR_DATA_O,
  output logic [AW-1:0]       FIFO_RD_ADDR_O,
  input  wire  logic [DW-1:0] FIFO_RD_DATA_I
);

  initial begin
    if (AW < 2 || AW > 16 || DW < 1) begin
      $error("frm_top: unsupported width or depth");
    end
  end

  // two-stage synchronisers for every port pin, third stage only for clock edges
  frm_pkg::frm_port_ctl_t   a_s1, a_s2, b_s1, b_s2;
  frm_pkg::frm_replay_ctl_t r_s1, r_s2;
  logic [DW-1:0]            ad_s1, ad_s2, bd_s1, bd_s2;
  logic                     a_clk_d, b_clk_d;     // previous synced clock levels

  always_ff @(posedge CLK_I) begin
    a_s1  <= PORT_A_CTL_I;
    a_s2  <= a_s1;
    b_s1  <= PORT_B_CTL_I;
    b_s2  <= b_s1;
    r_s1  <= PORT_B_REPLAY_I;
    r_s2  <= r_s1;
    ad_s1 <= PORT_A_DATA_BUS_I;
    ad_s2 <= ad_s1;
    bd_s1 <= PORT_B_DATA_BUS_I;
    bd_s2 <= bd_s1;
    a_clk_d <= a_s2.clk;
    b_clk_d <= b_s2.clk;
  end

  // port clock rising edges as one-cycle strobes
  wire a_edge = a_s2.clk & ~a_clk_d;
  wire b_edge = b_s2.clk & ~b_clk_d;

  // port access decode, shared by both ports
  function automatic logic acc(input frm_pkg::frm_port_ctl_t c, input logic wr,
                               input logic mail);
    acc = ~c.chip_sel_n & c.enable & (c.write_not_read == wr) & (c.mail_sel == mail);
  endfunction

  // state
  logic [AW:0]   wptr;           // write pointer, one extra wrap bit
  logic [AW:0]   wptr_seen;      // write pointer one cycle late, word already in the array
  logic [AW:0]   rptr;           // current read pointer, next word to load
  logic [AW:0]   out_ptr;        // location of the word in the output register
  logic [AW:0]   shadow;         // frozen location of the marked word
  logic          replay;         // replay mode active
  logic [1:0]    reads_past;     // reads since the mark, saturating
  logic          out_valid;      // output register holds a new word
  logic [DW-1:0] out_word;       // fifo output register
  logic [DW-1:0] mail_a_to_b;    // mail register one
  logic [DW-1:0] mail_b_to_a;    // mail register two
  logic          mail_one_full_n;
  logic          mail_two_full_n;
  logic          space_avail;    // write-side flags, port a edges only
  logic          space_s;
  logic          near_full_n;
  logic          near_full_s;
  logic          near_empty_n;   // read-side flag, port b edges only
  logic          near_empty_s;

  // port a requests
  wire a_fifo_wr = a_edge & acc(a_s2, 1'b1, 1'b0) & space_avail;
  wire a_mail_wr = a_edge & acc(a_s2, 1'b1, 1'b1) & mail_one_full_n;  // R16 R18
  wire a_mail_rd = a_edge & acc(a_s2, 1'b0, 1'b1);
  // port b requests
  wire b_fifo_rd = b_edge & acc(b_s2, 1'b0, 1'b0) & out_valid;  // R23
  wire b_mail_wr = b_edge & acc(b_s2, 1'b1, 1'b1) & mail_two_full_n;  // R17 R18
  wire b_mail_rd = b_edge & acc(b_s2, 1'b0, 1'b1);

  // replay mode control
  wire rp_enter = b_edge & ~replay & r_s2.hold & out_valid;  // R1
  wire rp_exit  = b_edge & replay & ~r_s2.hold;  // R2
  // the controller keeps from_mark low at exit; a high one then is not honoured
  wire rp_go    = b_edge & replay & r_s2.hold & r_s2.from_mark  // R6 R25
                  & (reads_past == `FRM_MIN_READS_PAST);  // R3 R5

  // pointer seen by the write-side flags: shadow in replay, current otherwise
  wire [AW:0] wr_base   = replay ? shadow : out_ptr + {{AW{1'b0}}, out_valid};  // R8 R13
  wire [AW:0] wptr_next = wptr + {{AW{1'b0}}, a_fifo_wr};
  wire [AW:0] wr_count  = wptr_next - wr_base;
  wire [AW:0] depth     = {1'b1, {AW{1'b0}}};
  wire [AW:0] nf_limit  = depth - {1'b0, NEAR_FULL_OFS_I};
  wire        space_raw = wr_count < depth;  // R10
  wire        nf_raw    = wr_count < nf_limit;  // R9 R24

  // words waiting in the array and count seen by the near-empty flag
  wire [AW:0] rd_base  = rp_go ? shadow + {{AW{1'b0}}, 1'b1} : rptr;  // R11
  // the array takes a word one cycle after wptr steps, so the read side uses the late copy
  wire        can_load = wptr_seen != rd_base;
  // loads only on port b edges, so a word never falls through between edges
  wire        load     = ~rp_go & can_load & b_edge & (b_fifo_rd | ~out_valid);
  wire [AW:0] rd_count = wptr_seen - rptr + {{AW{1'b0}}, out_valid};  // R7
  wire        ne_raw   = rd_count > {1'b0, NEAR_EMPTY_OFS_I};

  // array address: the marked word on a replay edge, else the next word
  assign FIFO_RD_ADDR_O = rp_go ? shadow[AW-1:0] : rptr[AW-1:0];

  // replay mode and pointers, all stepped on port b edges
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      replay     <= 1'b0;
      shadow     <= '0;
      reads_past <= 2'h0;
      rptr       <= '0;
      out_ptr    <= '0;
      out_valid  <= `FRM_RST_OUT_VALID;
      out_word   <= '0;
    end else begin
      if (rp_enter) begin
        replay     <= 1'b1;
        shadow     <= out_ptr;  // R1 R8
        reads_past <= 2'h0;
      end else if (rp_exit) begin
        replay <= 1'b0;  // R2 R13
      end
      if (rp_go) begin
        // marked word back in the output register, reads may follow at once
        out_word   <= FIFO_RD_DATA_I;  // R4
        out_ptr    <= shadow;
        rptr       <= shadow + {{AW{1'b0}}, 1'b1};  // R11
        out_valid  <= 1'b1;
        reads_past <= 2'h0;  // R5
      end else if (load) begin
        // each shift into the output register steps the current pointer
        out_word  <= FIFO_RD_DATA_I;  // R7
        out_ptr   <= rptr;
        rptr      <= rptr + {{AW{1'b0}}, 1'b1};
        out_valid <= 1'b1;
        if (b_fifo_rd && reads_past != `FRM_MIN_READS_PAST) begin
          reads_past <= reads_past + 2'h1;
        end
      end else if (b_fifo_rd) begin
        out_valid <= 1'b0;  // read drained the last word
        if (reads_past != `FRM_MIN_READS_PAST) begin
          reads_past <= reads_past + 2'h1;
        end
      end
    end
  end

  // near-empty: falls on the edge, rises after two port b edges
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      near_empty_n <= `FRM_RST_NEAR_EMPTY_N;
      near_empty_s <= 1'b0;
    end else if (b_edge) begin
      near_empty_s <= ne_raw;
      near_empty_n <= ne_raw & near_empty_s;  // R12
    end
  end

  // write-side flags: fall on the write, rise only after two port a edges
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      space_avail <= `FRM_RST_SPACE_AVAIL;
      space_s     <= 1'b1;
      near_full_n <= `FRM_RST_NEAR_FULL_N;
      near_full_s <= 1'b1;
    end else if (a_edge) begin
      space_s     <= space_raw;
      space_avail <= space_raw & space_s;  // R10 R14
      near_full_s <= nf_raw;
      near_full_n <= nf_raw & near_full_s;  // R9 R14
    end
  end

  // fifo writes to the core, registered strobe with address and data
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      wptr           <= '0;
      wptr_seen      <= '0;
      FIFO_WR_O      <= 1'b0;
      FIFO_WR_ADDR_O <= '0;
      FIFO_WR_DATA_O <= '0;
    end else begin
      FIFO_WR_O <= a_fifo_wr;  // writes go on during replay
      wptr_seen <= wptr;
      if (a_fifo_wr) begin
        FIFO_WR_ADDR_O <= wptr[AW-1:0];
        FIFO_WR_DATA_O <= ad_s2;
        wptr           <= wptr_next;
      end
    end
  end

  // mail registers keep data until rewritten; a write beats a free
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      mail_one_full_n <= `FRM_RST_MAIL_FULL_N;
      mail_two_full_n <= `FRM_RST_MAIL_FULL_N;
    end else begin
      if (b_mail_rd) begin
        mail_one_full_n <= 1'b1;  // R20
      end
      if (a_mail_wr) begin
        mail_one_full_n <= 1'b0;  // R18
      end
      if (a_mail_rd) begin
        mail_two_full_n <= 1'b1;  // R21
      end
      if (b_mail_wr) begin
        mail_two_full_n <= 1'b0;  // R18
      end
    end
  end

  // mail data has no reset; it only changes on an accepted write
  always_ff @(posedge CLK_I) begin
    if (a_mail_wr) begin
      mail_a_to_b <= ad_s2;  // R15 R16 R22
    end
    if (b_mail_wr) begin
      mail_b_to_a <= bd_s2;  // R15 R17 R22
    end
  end

  // data outputs from flops; port b picks the fifo or mail one
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      PORT_A_DATA_BUS_O <= '0;
      PORT_B_DATA_BUS_O <= '0;
    end else begin
      PORT_A_DATA_BUS_O <= mail_b_to_a;  // R19
      PORT_B_DATA_BUS_O <= b_s2.mail_sel ? mail_a_to_b : out_word;  // R19
    end
  end

  // drivers on while the port is selected for reading
  assign PORT_A_DATA_BUS_OE_O = ~a_s2.chip_sel_n & ~a_s2.write_not_read;
  assign PORT_B_DATA_BUS_OE_O = ~b_s2.chip_sel_n & ~b_s2.write_not_read;
  // flags
  assign IN_SPACE_AVAIL_O  = space_avail;
  assign NEAR_FULL_N_O     = near_full_n;
  assign OUT_WORD_VALID_O  = out_valid;
  assign NEAR_EMPTY_N_O    = near_empty_n;
  assign MAIL_ONE_FULL_N_O = mail_one_full_n;
  assign MAIL_TWO_FULL_N_O = mail_two_full_n;

endmodule
`default_nettype wire

/* File: tb/frm_top_chk.sv */
// port-level assertions for the replay and mail block
`timescale 1ns/100ps
`default_nettype none
module frm_top_chk (
  // clock and reset
  input wire logic                   CLK_I,
  input wire logic                   RST_B_I,
  // port pins
  input wire frm_pkg::frm_port_ctl_t PORT_A_CTL_I,
  input wire frm_pkg::frm_port_ctl_t PORT_B_CTL_I,
  // watched outputs
  input wire logic                   PORT_A_DATA_BUS_OE_O,
  input wire logic                   PORT_B_DATA_BUS_OE_O,
  input wire logic                   IN_SPACE_AVAIL_O,
  input wire logic                   MAIL_ONE_FULL_N_O,
  input wire logic                   MAIL_TWO_FULL_N_O,
  input wire logic                   FIFO_WR_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);
  // pins reach the flags through a 2-stage sync plus an edge flop
  a_mail_one_set: assert property ($fell(MAIL_ONE_FULL_N_O) |-> $past(PORT_A_CTL_I.mail_sel, 3)
    && $past(PORT_A_CTL_I.write_not_read, 3)) else $error("mail one set without port a write");
  a_mail_one_free: assert property ($rose(MAIL_ONE_FULL_N_O) |-> $past(PORT_B_CTL_I.mail_sel, 3)
    && !$past(PORT_B_CTL_I.write_not_read, 3)) else $error("mail one freed without b read");
  a_mail_two_set: assert property ($fell(MAIL_TWO_FULL_N_O) |-> $past(PORT_B_CTL_I.mail_sel, 3)
    && $past(PORT_B_CTL_I.write_not_read, 3)) else $error("mail two set without port b write");
  a_mail_two_free: assert property ($rose(MAIL_TWO_FULL_N_O) |-> $past(PORT_A_CTL_I.mail_sel, 3)
    && !$past(PORT_A_CTL_I.write_not_read, 3)) else $error("mail two freed without a read");
  // drive enables follow the synced select and direction
  a_oe_port_b: assert property ($past(RST_B_I, 2) |-> PORT_B_DATA_BUS_OE_O ==
    (!$past(PORT_B_CTL_I.chip_sel_n, 2) && !$past(PORT_B_CTL_I.write_not_read, 2)))
    else $error("port b enable wrong");
  a_oe_port_a: assert property ($past(RST_B_I, 2) |-> PORT_A_DATA_BUS_OE_O ==
    (!$past(PORT_A_CTL_I.chip_sel_n, 2) && !$past(PORT_A_CTL_I.write_not_read, 2)))
    else $error("port a enable wrong");
  a_wr_one_pulse: assert property (FIFO_WR_O |=> !FIFO_WR_O)
    else $error("array write longer than one cycle");
  a_wr_needs_room: assert property (FIFO_WR_O |-> $past(IN_SPACE_AVAIL_O))
    else $error("array write while full");
  a_wr_fifo_path: assert property (FIFO_WR_O |-> !$past(PORT_A_CTL_I.mail_sel, 3)
    && $past(PORT_A_CTL_I.write_not_read, 3)) else $error("array write not from fifo path");
endmodule
`default_nettype wire

/* File: tb/frm_core_mdl.sv */
// behavioural array behind the block: 1024 words, async read
`timescale 1ns/100ps
`default_nettype none
module frm_core_mdl (
  // array side
  input  wire logic        clk_i,
  input  wire logic        wr_i,
  input  wire logic [9:0]  wr_addr_i,
  input  wire logic [35:0] wr_data_i,
  input  wire logic [9:0]  rd_addr_i,
  output logic      [35:0] rd_data_o
);
  logic [35:0] mem [1024]; // unwritten words stay unknown on purpose
  // write one word per pulse
  always_ff @(posedge clk_i) begin
    if (wr_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end
  assign rd_data_o = mem[rd_addr_i]; // same-cycle read
endmodule
`default_nettype wire

/* File: tb/tb_frm_top.sv */
// self-checking bench for the replay and mail block
`timescale 1ns/100ps
`default_nettype none
module tb_frm_top;
  logic                     clk = 1'b0;
  logic                     rst_b = 1'b0;
  frm_pkg::frm_port_ctl_t   pa = 5'h08;
  frm_pkg::frm_port_ctl_t   pb = 5'h08;
  frm_pkg::frm_replay_ctl_t rp = 2'h0;
  logic [35:0]              da = 36'h0, db = 36'h0, ao, bo, wd, rd;
  logic                     aoe, boe, sp, nf, m1, m2, vld, ne, wr;
  logic [9:0]               wa, ra;
  int                       error_cnt = 0, total_checks = 0, cyc = 0;
  frm_top dut (.CLK_I(clk), .RST_B_I(rst_b), .PORT_A_CTL_I(pa), .PORT_A_DATA_BUS_I(da),
    .PORT_A_DATA_BUS_O(ao), .PORT_A_DATA_BUS_OE_O(aoe), .IN_SPACE_AVAIL_O(sp),
    .NEAR_FULL_N_O(nf), .MAIL_TWO_FULL_N_O(m2), .PORT_B_CTL_I(pb), .PORT_B_REPLAY_I(rp),
    .PORT_B_DATA_BUS_I(db), .PORT_B_DATA_BUS_O(bo), .PORT_B_DATA_BUS_OE_O(boe),
    .OUT_WORD_VALID_O(vld), .NEAR_EMPTY_N_O(ne), .MAIL_ONE_FULL_N_O(m1),
    .NEAR_EMPTY_OFS_I(10'h002), .NEAR_FULL_OFS_I(10'h008), .FIFO_WR_O(wr),
    .FIFO_WR_ADDR_O(wa), .FIFO_WR_DATA_O(wd), .FIFO_RD_ADDR_O(ra), .FIFO_RD_DATA_I(rd));
  frm_core_mdl core (.clk_i(clk), .wr_i(wr), .wr_addr_i(wa), .wr_data_i(wd),
    .rd_addr_i(ra), .rd_data_o(rd));
  // 20 MHz clock
  initial begin
    forever #25 clk = ~clk;
  end
  // compare and count
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one port clock cycle; c = {chip_sel_n, write_not_read, enable, mail_sel}
  // slow enough that sync, detect and data register have all settled on return
  task automatic cyc_p(input logic b, input logic [3:0] c, input logic [35:0] d,
                       input logic [1:0] r);
    @(negedge clk);
    if (b) begin
      pb = {1'b0, c};
      db = d;
      rp = r;
    end else begin
      pa = {1'b0, c};
      da = d;
    end
    @(negedge clk);
    if (b) pb.clk = 1'b1; else pa.clk = 1'b1;
    repeat (3) @(negedge clk);
    if (b) pb.clk = 1'b0; else pa.clk = 1'b0;
    repeat (3) @(negedge clk);
  endtask
  // verdict
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // hang guard, far above the roughly 185 cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      summarize();
    end
  end
  initial begin
    repeat (8) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    chk(vld, 0);
    chk(ne, 0);
    // mail one: write, refused rewrite, read twice
    cyc_p(0, 4'h7, 36'h123456789, 2'h0);
    chk(m1, 0);
    cyc_p(0, 4'h7, 36'hfedcba987, 2'h0);
    cyc_p(1, 4'h3, 36'h0, 2'h0);
    chk(bo, 36'h123456789);
    chk(m1, 1);
    chk(boe, 1);
    cyc_p(1, 4'h3, 36'h0, 2'h0);
    chk(bo, 36'h123456789);
    $display("mail one test done");
    // mail two: write on b, read on a
    cyc_p(1, 4'h7, 36'h0a5a5a5a5, 2'h0);
    chk(m2, 0);
    cyc_p(0, 4'h3, 36'h0, 2'h0);
    chk(ao, 36'h0a5a5a5a5);
    chk(m2, 1);
    $display("mail two test done");
    // fifo words then replay loops
    for (int i = 0; i < 4; i++) cyc_p(0, 4'h6, 36'h100 + 36'(i), 2'h0);
    chk(sp, 1);
    chk(nf, 1);
    cyc_p(1, 4'h8, 36'h0, 2'h1);
    chk(vld, 1);
    cyc_p(1, 4'h8, 36'h0, 2'h1);
    chk(bo, 36'h100);
    chk(ne, 1);
    cyc_p(1, 4'h8, 36'h0, 2'h2);
    for (int k = 0; k < 2; k++) begin
      for (int i = 1; i < 3; i++) begin
        cyc_p(1, 4'h2, 36'h0, 2'h2);
        chk(bo, 36'h100 + 36'(i));
      end
      cyc_p(1, 4'h8, 36'h0, 2'h3);
      chk(bo, 36'h100);
      chk(vld, 1);
    end
    cyc_p(1, 4'h2, 36'h0, 2'h2);
    chk(bo, 36'h101);
    cyc_p(1, 4'h8, 36'h0, 2'h0);
    cyc_p(1, 4'h2, 36'h0, 2'h0);
    chk(bo, 36'h102);
    $display("replay test done");
    summarize();
  end
endmodule
bind frm_top frm_top_chk chk (.CLK_I(CLK_I), .RST_B_I(RST_B_I), .PORT_A_CTL_I(PORT_A_CTL_I),
  .PORT_B_CTL_I(PORT_B_CTL_I), .PORT_A_DATA_BUS_OE_O(PORT_A_DATA_BUS_OE_O),
  .PORT_B_DATA_BUS_OE_O(PORT_B_DATA_BUS_OE_O), .IN_SPACE_AVAIL_O(IN_SPACE_AVAIL_O),
  .MAIL_ONE_FULL_N_O(MAIL_ONE_FULL_N_O), .MAIL_TWO_FULL_N_O(MAIL_TWO_FULL_N_O),
  .FIFO_WR_O(FIFO_WR_O));
`default_nettype wire
